/* hdl/tcei_pkg.sv */
package tcei_pkg;

  localparam int          BYTE_W          = 8;
  localparam int          I2C_ADDR_W      = 7;
  localparam int          BIT_CNT_W       = 3;
  localparam logic [2:0]  BIT_LAST        = 3'h7;

  // Register offsets
  localparam logic [7:0]  CTRL_OFF        = 8'h02;
  localparam logic [7:0]  EVT_FLAGS_OFF   = 8'h03;

  // Reset values
  localparam logic [7:0]  CTRL_RESET      = 8'h00;
  localparam logic [7:0]  PTR_RESET       = 8'h00;
  localparam logic [7:0]  UNMAPPED_DATA   = 8'h00;

  // Control register fields
  localparam int          CTRL_MASK_BIT   = 0;
  localparam int          CTRL_ROLE_LSB   = 1;
  localparam int          CTRL_ROLE_MSB   = 2;
  localparam int          CTRL_TRY_BIT    = 6;

  // Event register fields
  localparam int          EVT_ATTACH_BIT  = 0;
  localparam int          EVT_DETACH_BIT  = 1;
  localparam int          EVT_FAULT_BIT   = 2;
  localparam int          EVT_OTP_BIT     = 3;
  localparam int          EVT_RSVD_BIT    = 4;
  localparam int          EVT_OVP_BIT     = 5;
  localparam int          EVT_OCP_BIT     = 6;
  localparam int          EVT_RECOV_BIT   = 7;
  // Latched bits that may raise the interrupt: 7,6,5,3,1,0
  localparam logic [7:0]  EVT_STICKY_MASK = 8'hEB;

  // Edge detector lanes for the port-side levels
  localparam int          LN_OTP          = 0;
  localparam int          LN_OVP          = 1;
  localparam int          LN_OCP          = 2;
  localparam int          LN_FAULT        = 3;
  localparam int          LN_ATTACH       = 4;
  localparam int          LN_COUNT        = 5;

  typedef enum logic [1:0] {
    ROLE_SINK    = 2'h0,
    ROLE_SOURCE  = 2'h1,
    ROLE_DRP     = 2'h2,
    ROLE_DRP_TRY = 2'h3
  } tcei_role_code_t;

  typedef struct packed {
    logic over_current_event;
    logic over_voltage_event;
    logic otp;
  } tcei_fault_t;

  typedef struct packed {
    logic sink;
    logic source;
    logic drp;
    logic try_src;
    logic try_snk;
  } tcei_role_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_AACK = 3'h3,
    ST_WR   = 3'h2,
    ST_WACK = 3'h6,
    ST_RD   = 3'h7,
    ST_RACK = 3'h5
  } tcei_i2c_st_t;

endpackage : tcei_pkg

/* hdl/tcei_edge.sv */
`timescale 1ns/1ps
module tcei_edge #(
  parameter int W = 1
) (
  input  wire logic         clk,   // System clock
  input  wire logic         rstn,  // Synchronous reset, active low
  input  wire logic [W-1:0] sig,   // Levels to watch
  output logic      [W-1:0] rise,  // Low-to-high this cycle
  output logic      [W-1:0] fall   // High-to-low this cycle
);

  logic [W-1:0] prev_q;
  logic [W-1:0] prev_d;

  always_comb begin
    prev_d = sig;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      prev_q <= '0;
    end else begin
      prev_q <= prev_d;
    end
  end

  assign rise = sig & ~prev_q;
  assign fall = ~sig & prev_q;

endmodule : tcei_edge

/* hdl/tcei_sticky.sv */
`timescale 1ns/1ps
module tcei_sticky (
  input  wire logic clk,   // System clock
  input  wire logic rstn,  // Synchronous reset, active low
  input  wire logic set,   // Event seen
  input  wire logic clr,   // Clear by register read
  output logic      q      // Latched flag
);

  logic flag_q;
  logic flag_d;

  // A set in the clearing cycle survives
  always_comb begin
    flag_d = set | (flag_q & ~clr);
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign q = flag_q;

endmodule : tcei_sticky

/* hdl/tcei_top.sv */
// Notes on behaviour
// - Role field 00 gives sink, 01 source, 10 plain dual-role.
// - Role 11 is dual-role with try-source or try-sink from the preference bit.
// - Mask bit 0: interrupt pin driven low while an event is flagged.
// - Mask bit 1: events still latched, interrupt pin left undriven.
// - Event register resets to zero, read-only, cleared by a read of it.
// - Top bit set when VCONN recovers from any fault.
// - Over-current flag set on a VCONN over-current event.
// - Over-voltage flag set on a VCONN over-voltage event.
// - Bit four of the event register always reads zero.
// - Over-temperature flag set on a VCONN over-temperature event.
// - Fault-occurring bit shows live fault presence.
// - Fault-occurring bit is not cleared by reads and raises no interrupt.
// - Detach flag set on unplug.
// - Unplug means leaving any attached state for unattached.
// - Attach flag set on plug, unattached to attached.
`timescale 1ns/1ps
module tcei_top #(
  parameter logic [6:0] I2C_ADDR = 7'h1D          // Slave address
) (
  input  wire logic                 ref_clk,      // 100 MHz system clock
  input  wire logic                 rstn,         // Synchronous reset, active low
  input  wire logic                 scl_i,        // I2C clock level
  input  wire logic                 sda_i,        // I2C data level
  output logic                      sda_o,        // I2C data drive value, always low
  output logic                      sda_oe,       // High while pulling SDA low
  input  wire tcei_pkg::tcei_fault_t faults,      // Live VCONN fault levels
  input  wire logic                 attached,     // Port in any attached state
  output logic                      irq_out_n_o,  // Interrupt drive value, always low
  output logic                      irq_out_n_oe, // High while pulling interrupt low
  output tcei_pkg::tcei_role_t      role,         // Decoded port role
  output logic [7:0]                ctrl_o        // Control byte for the port logic
);

  tcei_pkg::tcei_i2c_st_t st_q;
  tcei_pkg::tcei_i2c_st_t st_d;
  logic [2:0]             cnt_q;
  logic [2:0]             cnt_d;
  logic                   done_q;
  logic                   done_d;
  logic [7:0]             shr_q;
  logic [7:0]             shr_d;
  logic                   rw_q;
  logic                   rw_d;
  logic                   first_q;
  logic                   first_d;
  logic [7:0]             ptr_q;
  logic [7:0]             ptr_d;
  logic                   sda_oe_q;
  logic                   sda_oe_d;
  logic                   mack_q;
  logic                   mack_d;
  logic [7:0]             ctrl_q;
  logic [7:0]             ctrl_d;
  logic                   irq_oe_q;
  logic                   irq_oe_d;
  logic                   fault_q;
  logic                   fault_d;
  tcei_pkg::tcei_role_t   role_q;
  tcei_pkg::tcei_role_t   role_d;

  logic [1:0]             bus_rise;
  logic [1:0]             bus_fall;
  logic                   scl_rise;
  logic                   scl_fall;
  logic                   start_c;
  logic                   stop_c;
  logic                   clr_evt;
  logic                   wr_en;
  logic [7:0]             rd_data;
  logic [7:0]             evt_view;
  logic [7:0]             flags;
  logic [7:0]             set_vec;
  logic                   fault_any;
  logic [tcei_pkg::LN_COUNT-1:0] lvl;
  logic [tcei_pkg::LN_COUNT-1:0] lvl_rise;
  logic [tcei_pkg::LN_COUNT-1:0] lvl_fall;

  // Bus edges: lane 1 is SCL, lane 0 is SDA
  tcei_edge #(.W(2)) u_bus_edge (
    .clk  (ref_clk),
    .rstn (rstn),
    .sig  ({scl_i, sda_i}),
    .rise (bus_rise),
    .fall (bus_fall)
  );

  assign scl_rise = bus_rise[1];
  assign scl_fall = bus_fall[1];
  // SDA moving while SCL stays high frames a transfer
  assign start_c  = scl_i & ~bus_rise[1] & bus_fall[0];
  assign stop_c   = scl_i & ~bus_rise[1] & bus_rise[0];

  assign fault_any = |faults;
  assign lvl       = {attached, fault_any, faults.over_current_event, faults.over_voltage_event, faults.otp};

  tcei_edge #(.W(tcei_pkg::LN_COUNT)) u_port_edge (
    .clk  (ref_clk),
    .rstn (rstn),
    .sig  (lvl),
    .rise (lvl_rise),
    .fall (lvl_fall)
  );

  always_comb begin
    set_vec                          = '0;
    set_vec[tcei_pkg::EVT_RECOV_BIT]  = lvl_fall[tcei_pkg::LN_FAULT];
    set_vec[tcei_pkg::EVT_OCP_BIT]    = lvl_rise[tcei_pkg::LN_OCP];
    set_vec[tcei_pkg::EVT_OVP_BIT]    = lvl_rise[tcei_pkg::LN_OVP];
    set_vec[tcei_pkg::EVT_OTP_BIT]    = lvl_rise[tcei_pkg::LN_OTP];
    set_vec[tcei_pkg::EVT_DETACH_BIT] = lvl_fall[tcei_pkg::LN_ATTACH];
    set_vec[tcei_pkg::EVT_ATTACH_BIT] = lvl_rise[tcei_pkg::LN_ATTACH];
  end

  // Bits 4 and 2 never latch; their set lanes stay low
  for (genvar b = 0; b < tcei_pkg::BYTE_W; b++) begin : g_flag
    tcei_sticky u_flag (
      .clk  (ref_clk),
      .rstn (rstn),
      .set  (set_vec[b] & tcei_pkg::EVT_STICKY_MASK[b]),
      .clr  (clr_evt),
      .q    (flags[b])
    );
  end

  always_comb begin
    evt_view                         = flags & tcei_pkg::EVT_STICKY_MASK;
    evt_view[tcei_pkg::EVT_FAULT_BIT] = fault_q;
  end

  always_comb begin
    unique case (ptr_q)
      tcei_pkg::CTRL_OFF:      rd_data = ctrl_q;
      tcei_pkg::EVT_FLAGS_OFF: rd_data = evt_view;
      default:                 rd_data = tcei_pkg::UNMAPPED_DATA;
    endcase
  end

  // I2C slave: pointer byte first on writes, auto-increment on both directions
  always_comb begin
    st_d     = st_q;
    cnt_d    = cnt_q;
    done_d   = done_q;
    shr_d    = shr_q;
    rw_d     = rw_q;
    first_d  = first_q;
    ptr_d    = ptr_q;
    sda_oe_d = sda_oe_q;
    mack_d   = mack_q;
    clr_evt  = 1'b0;
    wr_en    = 1'b0;
    if (start_c) begin
      st_d     = tcei_pkg::ST_ADDR;
      cnt_d    = '0;
      done_d   = 1'b0;
      sda_oe_d = 1'b0;
    end else if (stop_c) begin
      st_d     = tcei_pkg::ST_IDLE;
      sda_oe_d = 1'b0;
    end else begin
      unique case (st_q)
        tcei_pkg::ST_IDLE: begin
        end
        tcei_pkg::ST_ADDR, tcei_pkg::ST_WR: begin
          if (scl_rise) begin
            shr_d  = {shr_q[6:0], sda_i};
            cnt_d  = cnt_q + 3'h1;
            done_d = (cnt_q == tcei_pkg::BIT_LAST);
          end else if (scl_fall && done_q) begin
            done_d = 1'b0;
            if (st_q == tcei_pkg::ST_ADDR) begin
              if (shr_q[7:1] == I2C_ADDR) begin
                sda_oe_d = 1'b1;
                rw_d     = shr_q[0];
                first_d  = 1'b1;
                st_d     = tcei_pkg::ST_AACK;
              end else begin
                st_d = tcei_pkg::ST_IDLE;
              end
            end else begin
              sda_oe_d = 1'b1;
              first_d  = 1'b0;
              st_d     = tcei_pkg::ST_WACK;
              if (first_q) begin
                ptr_d = shr_q;
              end else begin
                wr_en = 1'b1;
                ptr_d = ptr_q + 8'h01;
              end
            end
          end
        end
        tcei_pkg::ST_AACK: begin
          if (scl_fall) begin
            if (rw_q) begin
              shr_d    = rd_data;
              sda_oe_d = ~rd_data[7];
              cnt_d    = '0;
              ptr_d    = ptr_q + 8'h01;
              clr_evt  = (ptr_q == tcei_pkg::EVT_FLAGS_OFF);
              st_d     = tcei_pkg::ST_RD;
            end else begin
              sda_oe_d = 1'b0;
              st_d     = tcei_pkg::ST_WR;
            end
          end
        end
        tcei_pkg::ST_WACK: begin
          if (scl_fall) begin
            sda_oe_d = 1'b0;
            st_d     = tcei_pkg::ST_WR;
          end
        end
        tcei_pkg::ST_RD: begin
          if (scl_rise) begin
            cnt_d  = cnt_q + 3'h1;
            done_d = (cnt_q == tcei_pkg::BIT_LAST);
          end else if (scl_fall) begin
            if (done_q) begin
              done_d   = 1'b0;
              sda_oe_d = 1'b0;
              st_d     = tcei_pkg::ST_RACK;
            end else begin
              shr_d    = {shr_q[6:0], 1'b0};
              sda_oe_d = ~shr_q[6];
            end
          end
        end
        tcei_pkg::ST_RACK: begin
          if (scl_rise) begin
            mack_d = ~sda_i;
          end else if (scl_fall) begin
            if (mack_q) begin
              shr_d    = rd_data;
              sda_oe_d = ~rd_data[7];
              cnt_d    = '0;
              ptr_d    = ptr_q + 8'h01;
              clr_evt  = (ptr_q == tcei_pkg::EVT_FLAGS_OFF);
              st_d     = tcei_pkg::ST_RD;
            end else begin
              st_d = tcei_pkg::ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_en && ptr_q == tcei_pkg::CTRL_OFF) begin
      ctrl_d = shr_q;
    end
    fault_d  = fault_any;
    // The live fault bit is left out of the interrupt term on purpose
    irq_oe_d = ~ctrl_q[tcei_pkg::CTRL_MASK_BIT]
             & |(flags & tcei_pkg::EVT_STICKY_MASK);
  end

  always_comb begin
    role_d = '0;
    unique case (tcei_pkg::tcei_role_code_t'(
                 ctrl_q[tcei_pkg::CTRL_ROLE_MSB:tcei_pkg::CTRL_ROLE_LSB]))
      tcei_pkg::ROLE_SINK:    role_d.sink   = 1'b1;
      tcei_pkg::ROLE_SOURCE:  role_d.source = 1'b1;
      tcei_pkg::ROLE_DRP:     role_d.drp    = 1'b1;
      tcei_pkg::ROLE_DRP_TRY: begin
        role_d.drp     = 1'b1;
        role_d.try_src = ~ctrl_q[tcei_pkg::CTRL_TRY_BIT];
        role_d.try_snk = ctrl_q[tcei_pkg::CTRL_TRY_BIT];
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      st_q     <= tcei_pkg::ST_IDLE;
      cnt_q    <= '0;
      done_q   <= 1'b0;
      shr_q    <= '0;
      rw_q     <= 1'b0;
      first_q  <= 1'b0;
      ptr_q    <= tcei_pkg::PTR_RESET;
      sda_oe_q <= 1'b0;
      mack_q   <= 1'b0;
      ctrl_q   <= tcei_pkg::CTRL_RESET;
      irq_oe_q <= 1'b0;
      fault_q  <= 1'b0;
      role_q   <= '0;
    end else begin
      st_q     <= st_d;
      cnt_q    <= cnt_d;
      done_q   <= done_d;
      shr_q    <= shr_d;
      rw_q     <= rw_d;
      first_q  <= first_d;
      ptr_q    <= ptr_d;
      sda_oe_q <= sda_oe_d;
      mack_q   <= mack_d;
      ctrl_q   <= ctrl_d;
      irq_oe_q <= irq_oe_d;
      fault_q  <= fault_d;
      role_q   <= role_d;
    end
  end

  // Open-drain pins only ever pull low
  assign sda_o        = 1'b0;
  assign sda_oe       = sda_oe_q;
  assign irq_out_n_o  = 1'b0;
  assign irq_out_n_oe = irq_oe_q;
  assign role         = role_q;
  assign ctrl_o       = ctrl_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_role_sink: assert property (
    ctrl_q[2:1] == tcei_pkg::ROLE_SINK |=> role_q.sink && !role_q.drp && !role_q.source)
    else $error("sink role not decoded");
  a_role_try_src: assert property (
    ctrl_q[2:1] == tcei_pkg::ROLE_DRP_TRY && !ctrl_q[tcei_pkg::CTRL_TRY_BIT]
    |=> role_q.drp && role_q.try_src && !role_q.try_snk)
    else $error("try-source variant not decoded");
  a_irq_drive_low: assert property (
    lvl_rise[tcei_pkg::LN_OCP] && !clr_evt && !ctrl_q[tcei_pkg::CTRL_MASK_BIT]
    ##1 !ctrl_q[tcei_pkg::CTRL_MASK_BIT] |=> irq_oe_q)
    else $error("unmasked event did not pull interrupt low");
  a_mask_release: assert property (
    ctrl_q[tcei_pkg::CTRL_MASK_BIT] |=> !irq_oe_q)
    else $error("interrupt driven while masked");
  a_read_clears: assert property (
    clr_evt && set_vec == '0 |=> (flags & tcei_pkg::EVT_STICKY_MASK) == '0)
    else $error("event flags survived a read");
  a_recover_flag: assert property (
    lvl_fall[tcei_pkg::LN_FAULT] |=> flags[tcei_pkg::EVT_RECOV_BIT])
    else $error("recovery not latched");
  a_ocp_flag: assert property (
    $rose(faults.over_current_event) |=> evt_view[tcei_pkg::EVT_OCP_BIT])
    else $error("over-current not latched");
  a_ovp_flag: assert property (
    $rose(faults.over_voltage_event) |=> evt_view[tcei_pkg::EVT_OVP_BIT])
    else $error("over-voltage not latched");
  a_rsvd_zero: assert property (
    !evt_view[tcei_pkg::EVT_RSVD_BIT] && !rd_data[tcei_pkg::EVT_RSVD_BIT]
    || ptr_q != tcei_pkg::EVT_FLAGS_OFF)
    else $error("reserved event bit nonzero");
  a_otp_flag: assert property (
    $rose(faults.otp) |=> evt_view[tcei_pkg::EVT_OTP_BIT])
    else $error("over-temperature not latched");
  a_fault_live: assert property (
    fault_any ##1 fault_any |-> evt_view[tcei_pkg::EVT_FAULT_BIT])
    else $error("live fault bit not tracking");
  a_fault_no_irq: assert property (
    (flags & tcei_pkg::EVT_STICKY_MASK) == '0 && fault_q |=> !irq_oe_q)
    else $error("live fault raised interrupt");
  a_detach_flag: assert property (
    $fell(attached) |=> flags[tcei_pkg::EVT_DETACH_BIT])
    else $error("unplug not latched");
  a_attach_flag: assert property (
    $rose(attached) |=> flags[tcei_pkg::EVT_ATTACH_BIT])
    else $error("plug not latched");
  a_irq_release: assert property (
    clr_evt && set_vec == '0 ##1 set_vec == '0 |=> !irq_oe_q)
    else $error("interrupt held after clearing read");

  c_evt_read:   cover property (clr_evt);
  c_ctrl_write: cover property (wr_en && ptr_q == tcei_pkg::CTRL_OFF);
  c_irq_cycle:  cover property (irq_oe_q ##[1:1000] !irq_oe_q);
  c_try_snk:    cover property (role_q.try_snk);

endmodule : tcei_top

/* verif/tcei_host_model.sv */
`timescale 1ns/1ps
module tcei_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h1D  // Target address of the device
) (
  input  wire logic clk,     // System clock
  input  wire logic sda_in,  // Resolved SDA level
  input  wire logic irq_n,   // Resolved interrupt line, pulled up
  output logic      scl_oe,  // High while pulling SCL low
  output logic      sda_oe   // High while pulling SDA low
);
  // Cycles per SCL phase; the device needs at least 3
  int hp = 5;

  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end

  task automatic half();
    repeat (hp) @(posedge clk);
    #1;
  endtask : half

  task automatic start();
    half();
    sda_oe = 1'b1;
    half();
    scl_oe = 1'b1;
  endtask : start

  task automatic stop();
    sda_oe = 1'b1;
    half();
    scl_oe = 1'b0;
    half();
    sda_oe = 1'b0;
    half();
  endtask : stop

  // Two cycles of hold after SCL falls; the first bit after start() moves SDA as SCL falls
  task automatic xbit(input logic b, output logic s);
    sda_oe = ~b;
    half();
    scl_oe = 1'b0;
    half();
    s = sda_in;
    scl_oe = 1'b1;
    repeat (2) @(posedge clk);
    #1;
  endtask : xbit

  task automatic xbyte(input logic [7:0] d, input logic rel, output logic [7:0] q,
                       output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
    xbit(rel, s);
    ack = ~s;
  endtask : xbyte

  task automatic write_bytes(input logic [6:0] addr, input logic [7:0] ptr,
                             input logic [7:0] data, input bit with_data, output logic ok);
    logic [7:0] q;
    logic       a0;
    logic       a1;
    logic       a2;
    a2 = 1'b1;
    start();
    xbyte({addr, 1'b0}, 1'b1, q, a0);
    xbyte(ptr, 1'b1, q, a1);
    if (with_data) xbyte(data, 1'b1, q, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask : write_bytes

  // Single-byte read ends with a NACK from the host
  task automatic read_reg(input logic [7:0] ptr, output logic [7:0] data, output logic ok);
    logic a0;
    logic a1;
    logic n;
    write_bytes(DEV_ADDR, ptr, 8'h00, 1'b0, a0);
    start();
    xbyte({DEV_ADDR, 1'b1}, 1'b1, data, a1);
    xbyte(8'hFF, 1'b1, data, n);
    stop();
    ok = a0 & a1;
  endtask : read_reg

  task automatic service_irq(output logic [7:0] data, output logic seen, output logic ok);
    seen = 1'b0;
    ok   = 1'b0;
    data = 8'h00;
    for (int i = 0; i < 200 && !seen; i++) begin
      @(posedge clk);
      seen = (irq_n === 1'b0);
    end
    #1;
    if (seen) read_reg(tcei_pkg::EVT_FLAGS_OFF, data, ok);
  endtask : service_irq
endmodule : tcei_host_model

/* verif/typec_event_interrupt_regs_tb.sv */
`timescale 1ns/1ps
module typec_event_interrupt_regs_tb;
  localparam logic [6:0] DEV_ADDR = 7'h2A;

  logic                  ref_clk;
  logic                  rstn;
  tcei_pkg::tcei_fault_t faults;
  logic                  attached;
  logic                  h_scl_oe;
  logic                  h_sda_oe;
  logic                  sda_o;
  logic                  sda_oe;
  logic                  irq_o;
  logic                  irq_oe;
  tcei_pkg::tcei_role_t  role;
  logic [7:0]            ctrl_o;
  logic                  scl_w;
  logic                  sda_w;
  logic                  irq_w;
  int                    fails;
  int                    checks_done;
  logic [7:0]            exp_flags;
  logic                  mask;
  logic [2:0]            cur_f;
  logic                  cur_a;

  // All three open-drain lines (SCL, SDA, interrupt) have pull-ups
  assign scl_w = h_scl_oe ? 1'b0 : 1'b1;
  assign sda_w = h_sda_oe ? 1'b0 : (sda_oe ? sda_o : 1'b1);
  assign irq_w = irq_oe ? irq_o : 1'b1;

  tcei_top #(.I2C_ADDR(DEV_ADDR)) dut (
    .ref_clk(ref_clk), .rstn(rstn), .scl_i(scl_w), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe(sda_oe), .faults(faults), .attached(attached), .irq_out_n_o(irq_o),
    .irq_out_n_oe(irq_oe), .role(role), .ctrl_o(ctrl_o));

  tcei_host_model #(.DEV_ADDR(DEV_ADDR)) host (
    .clk(ref_clk), .sda_in(sda_w), .irq_n(irq_w), .scl_oe(h_scl_oe), .sda_oe(h_sda_oe));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic give_verdict();
    $display("checks_done %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", name, e, g);
      fails++;
    end
  endtask : chk

  function automatic logic [4:0] exp_role(input logic [7:0] c);
    case (c[2:1])
      2'h0:    return 5'h10;
      2'h1:    return 5'h08;
      2'h2:    return 5'h04;
      default: return c[6] ? 5'h05 : 5'h06;
    endcase
  endfunction : exp_role

  // Flags latched by one step of the live levels
  function automatic logic [7:0] evt_step(input logic [7:0] e, input logic [2:0] pf,
                                          input logic [2:0] nf, input logic pa, input logic na);
    logic [7:0] r;
    r = e;
    if (nf[2] && !pf[2]) r[6] = 1'b1;
    if (nf[1] && !pf[1]) r[5] = 1'b1;
    if (nf[0] && !pf[0]) r[3] = 1'b1;
    if ((|pf) && !(|nf)) r[7] = 1'b1;
    if (na && !pa) r[0] = 1'b1;
    if (!na && pa) r[1] = 1'b1;
    return r;
  endfunction : evt_step

  task automatic wr(input logic [7:0] ptr, input logic [7:0] data);
    logic ok;
    host.write_bytes(DEV_ADDR, ptr, data, 1'b1, ok);
    chk("write ack", 8'h01, {7'h0, ok});
  endtask : wr

  task automatic rd_chk(input string name, input logic [7:0] ptr, input logic [7:0] e);
    logic [7:0] d;
    logic       ok;
    host.read_reg(ptr, d, ok);
    chk("read ack", 8'h01, {7'h0, ok});
    chk(name, e, d);
  endtask : rd_chk

  task automatic apply(input logic [2:0] nf, input logic na);
    logic [7:0] d;
    logic       seen;
    logic       ok;
    exp_flags = evt_step(exp_flags, cur_f, nf, cur_a, na);
    faults    = nf;
    attached  = na;
    cur_f     = nf;
    cur_a     = na;
    repeat (4) @(posedge ref_clk);
    #1;
    chk("irq line", {7'h0, !(!mask && |exp_flags)}, {7'h0, irq_w});
    if (!mask && |exp_flags) begin
      host.service_irq(d, seen, ok);
      chk("irq read ack", 8'h01, {7'h0, ok});
      chk("flags", exp_flags | {5'h0, |nf, 2'h0}, d);
    end else begin
      rd_chk("flags", tcei_pkg::EVT_FLAGS_OFF, exp_flags | {5'h0, |nf, 2'h0});
    end
    exp_flags = 8'h00;
    chk("irq released", 8'h01, {7'h0, irq_w});
  endtask : apply

  initial begin
    logic       ok;
    logic [7:0] c;
    int         seed_v;
    rstn      = 1'b0;
    faults    = '0;
    attached  = 1'b0;
    fails     = 0;
    checks_done = 0;
    exp_flags = 8'h00;
    mask      = 1'b0;
    cur_f     = 3'h0;
    cur_a     = 1'b0;
    seed_v    = $urandom(15);
    repeat (6) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    chk("ctrl reset", tcei_pkg::CTRL_RESET, ctrl_o);
    chk("role reset", {3'h0, exp_role(8'h00)}, {3'h0, role});
    chk("irq reset", 8'h01, {7'h0, irq_w});
    rd_chk("flags reset", tcei_pkg::EVT_FLAGS_OFF, 8'h00);
    for (int i = 0; i < 8; i++) begin
      c = {1'b0, i[2], 3'h0, i[1:0], 1'b0};
      wr(tcei_pkg::CTRL_OFF, c);
      repeat (3) @(posedge ref_clk);
      #1;
      chk("role", {3'h0, exp_role(c)}, {3'h0, role});
      rd_chk("ctrl readback", tcei_pkg::CTRL_OFF, c);
    end
    wr(tcei_pkg::CTRL_OFF, 8'h00);
    wr(tcei_pkg::EVT_FLAGS_OFF, 8'hFF);
    rd_chk("flags after write", tcei_pkg::EVT_FLAGS_OFF, 8'h00);
    rd_chk("unmapped", 8'h10, tcei_pkg::UNMAPPED_DATA);
    host.write_bytes(DEV_ADDR ^ 7'h01, tcei_pkg::CTRL_OFF, 8'h01, 1'b1, ok);
    chk("foreign ack", 8'h00, {7'h0, ok});
    chk("ctrl kept", 8'h00, ctrl_o);
    for (int k = 0; k < 3; k++) begin
      apply(3'h1 << k, 1'b0);
      apply(3'h0, 1'b0);
    end
    apply(3'h0, 1'b1);
    apply(3'h0, 1'b0);
    apply(3'h3, 1'b1);
    rd_chk("live fault", tcei_pkg::EVT_FLAGS_OFF, 8'h04);
    chk("no irq from live bit", 8'h01, {7'h0, irq_w});
    apply(3'h0, 1'b0);
    // Masked phase with a faster host
    mask    = 1'b1;
    host.hp = 3;
    wr(tcei_pkg::CTRL_OFF, 8'h01);
    chk("ctrl mask", 8'h01, ctrl_o);
    for (int n = 0; n < 6; n++) apply(3'($urandom), 1'($urandom));
    mask    = 1'b0;
    host.hp = 5;
    wr(tcei_pkg::CTRL_OFF, 8'h00);
    for (int n = 0; n < 10; n++) apply(3'($urandom), 1'($urandom));
    give_verdict();
  end

  // Expected run is near 220 us; the limit stays well under 100k cycles
  initial begin
    #600_000;
    fails++;
    $display("[FAIL] watchdog expected end seen hang");
    give_verdict();
  end
endmodule : typec_event_interrupt_regs_tb
